// >>> test_tsr_reg_bank.sv
/* self-checking bench; assumes tsr_master and the bound checker compiled first. */
`timescale 1ns/10ps
module test_tsr_reg_bank;
    reg clk_sys = 1'b0, reset_n = 1'b0, motion_detect = 1'b0, nvm_load_stb = 1'b0;
    reg [16:0] object_raw_sample = 17'h1a5c3;
    reg [14:0] ambient_raw_sample = 15'h5e71;
    reg [19:0] object_filter_fast = 20'h9b2d4, object_filter_slow = 20'h3c6e8;
    reg [15:0] ambient_filtered = 16'hb417;
    reg [7:0] presence_magnitude = 8'h4d, motion_magnitude = 8'h92;
    reg [7:0] ambient_jump_magnitude = 8'h2b, live_condition_status = 8'he6;
    reg [7:0] bus_device_address = 8'h5b, nvm_load_data = 8'h3c;
    reg [4:0] evt_flag = 5'h00, nvm_load_addr = 5'h1e;
    reg [2:0] evt_sign = 3'h0;
    wire ptr_load, wr_stb, rd_stb, overtemp_dir, int_n;
    wire [7:0] ptr_load_addr, wr_data, rd_data, presence_threshold, motion_threshold;
    wire [7:0] ambient_jump_threshold, periodic_timer_setting, nvm_access_control;
    wire [3:0] fast_filter_constant, slow_filter_constant, ambient_filter_constant;
    wire [4:0] interrupt_enable_mask;
    wire [1:0] motion_cycle_sel, presence_src_sel;
    wire [15:0] overtemp_threshold;
    integer n_errors = 0, comparisons = 0, i;
    reg [151:0] e;
    tsr_reg_bank uut (.*);
    tsr_master m (.clk_sys, .rd_data, .ptr_load, .ptr_load_addr, .wr_stb, .wr_data, .rd_stb);
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("Error %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        #20000 n_errors = n_errors + 1;
        finish_test;
    end
    // control burst written and read back, reserved bits dropped
    task t_ctrl;
        begin
            m.init;
            m.go(3'b100, 8'h14);
            for (i = 0; i < 12; i = i + 1)
                m.go(3'b010, 8'hd0 ^ i[7:0]);
            m.go(3'b100, 8'h14);
            for (i = 0; i < 12; i = i + 1) begin
                m.go(3'b001, 8'h00);
                e[7:0] = i == 1 ? 8'h0f : i == 5 || i == 6 ? 8'h1f : i == 10 ? 8'h00 : 8'hff;
                chk(m.got, (8'hd0 ^ i[7:0]) & e[7:0]);
            end
            chk(overtemp_threshold, 16'hd8d9);
            chk({motion_threshold, ambient_jump_threshold}, 16'hd3d4);
            chk({periodic_timer_setting, nvm_access_control}, 16'hd7db);
            chk({ambient_filter_constant, interrupt_enable_mask, overtemp_dir, presence_src_sel,
                motion_cycle_sel, 2'h0}, 16'h1ad8);
        end
    endtask
    // read-only writes dropped, pointer steps on and wraps past 63
    task t_wrap;
        begin
            nvm_load_stb = 1'b1;
            m.go(3'b100, 8'h0f);
            nvm_load_stb = 1'b0;
            for (i = 0; i < 6; i = i + 1)
                m.go(3'b010, 8'h5a);
            m.go(3'b100, 8'h3e);
            e[23:0] = {nvm_load_data, bus_device_address, 8'h00};
            for (i = 0; i < 3; i = i + 1) begin
                m.go(3'b001, 8'h00);
                chk(m.got, e[23 - 8 * i -: 8]);
            end
            chk({presence_threshold, slow_filter_constant, fast_filter_constant}, 16'hd25a);
        end
    endtask
    // sample bytes in one burst, most significant first
    task t_samp;
        begin
            motion_detect = 1'b1;
            m.go(3'b000, 8'h00);
            motion_detect = 1'b0;
            m.go(3'b100, 8'h01);
            e = {object_raw_sample, ambient_raw_sample, object_filter_fast, object_filter_slow,
                ambient_filtered, object_filter_slow, 4'h0, presence_magnitude, motion_magnitude,
                ambient_jump_magnitude, 8'h00, live_condition_status};
            for (i = 0; i < 19; i = i + 1) begin
                m.go(3'b001, 8'h00);
                chk(m.got, e[151 - 8 * i -: 8]);
            end
        end
    endtask
    // each enabled event drives the pin low, the masked sixth one does not; a status read returns it and releases the pin
    task t_irq;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                m.go(3'b100, 8'h19);
                m.go(3'b010, i < 5 ? 8'h1f : 8'h00);
                evt_flag = 5'h01 << (i % 5);
                evt_sign = 3'h7;
                m.go(3'b000, 8'h00);
                evt_flag = 5'h00;
                evt_sign = 3'h0;
                m.go(3'b100, 8'h12);
                chk(int_n, i == 5);
                m.go(3'b001, 8'h00);
                e[7:0] = (8'h01 << (i % 5)) | (i % 5 > 0 && i % 5 < 4 ? 8'h10 << (i % 5) : 8'h00);
                chk(m.got, e[7:0]);
                m.go(3'b000, 8'h00);
                chk(int_n, 1'b1);
            end
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        t_ctrl;
        t_wrap;
        t_samp;
        t_irq;
        finish_test;
    end
endmodule

// >>> tsr_addr_ptr.v
/*
 * tsr_addr_ptr.v: register address pointer with auto-increment.
 * Assumes: load and advance come from the serial engine, synchronous
 * to clk_sys; only the low six address bits are kept.
 */
`timescale 1ns/10ps
`include "tsr_consts.vh"

module tsr_addr_ptr (
    clk_sys,
    reset_n,
    ptr_load,
    ptr_load_addr,
    ptr_advance,
    ptr_value
);
    input        clk_sys;
    input        reset_n;
    input        ptr_load;
    input  [7:0] ptr_load_addr;
    input        ptr_advance;
    output [5:0] ptr_value;

    reg    [5:0] ptr_ff;
    reg    [5:0] nxt_ptr;

    // ======================================================
    // next pointer: load wins, else step and wrap past 63
    // ======================================================
    always @* begin
        nxt_ptr = ptr_ff;
        if (ptr_load) begin
            nxt_ptr = ptr_load_addr[5:0];
        end else if (ptr_advance) begin
            if (ptr_ff == `TSR_A_LAST) begin
                nxt_ptr = `TSR_RST_PTR;
            end else begin
                nxt_ptr = ptr_ff + 6'h01;
            end
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ptr_ff <= `TSR_RST_PTR;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    assign ptr_value = ptr_ff;
endmodule

// >>> tsr_consts.vh
/*
 * tsr_consts.vh: register offsets, field positions, write masks and
 * reset values of the thermal sensor register bank.
 * Assumes: included by its bare name; definitions only.
 */
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH

// ==========================================================
// register offsets (byte addresses)
// ==========================================================
`define TSR_A_RSVD0        6'h00
`define TSR_A_OBJ_RAW      6'h01
`define TSR_A_AMB_RAW      6'h03
`define TSR_A_OBJ_FAST     6'h05
`define TSR_A_OBJ_SLOW     6'h07
`define TSR_A_AMB_FILT     6'h0a
`define TSR_A_SNAP         6'h0c
`define TSR_A_PRES_MAG     6'h0f
`define TSR_A_MOT_MAG      6'h10
`define TSR_A_JUMP_MAG     6'h11
`define TSR_A_INT_STAT     6'h12
`define TSR_A_LIVE_STAT    6'h13
`define TSR_A_FILT12       6'h14
`define TSR_A_FILT3        6'h15
`define TSR_A_PRES_THR     6'h16
`define TSR_A_MOT_THR      6'h17
`define TSR_A_JUMP_THR     6'h18
`define TSR_A_INT_MASK     6'h19
`define TSR_A_DET_CFG      6'h1a
`define TSR_A_TIMER        6'h1b
`define TSR_A_OT_THR       6'h1c
`define TSR_A_RSVD30       6'h1e
`define TSR_A_NVM_CTRL     6'h1f
`define TSR_A_NVM_FIRST    6'h20
`define TSR_A_NVM_LAST     6'h3e
`define TSR_A_BUS_ADDR     6'h3f
`define TSR_A_LAST         6'h3f

// ==========================================================
// write masks for partly reserved registers
// ==========================================================
`define TSR_M_FILT3        8'h0f
`define TSR_M_INT_MASK     8'h1f
`define TSR_M_DET_CFG      8'h1f

// ==========================================================
// field positions
// ==========================================================
`define TSR_F_CYCLE_LSB    0
`define TSR_F_SRC_LSB      2
`define TSR_F_OT_DIR       4
`define TSR_F_SIGN_LSB     5
`define TSR_N_FLAGS        5
`define TSR_N_SIGNS        3
`define TSR_SNAP_SHIFT     4

// ==========================================================
// reset values
// ==========================================================
`define TSR_RST_BYTE       8'h00
`define TSR_RST_WORD       16'h0000
`define TSR_RST_PTR        6'h00

`endif

// >>> tsr_irq_latch.v
/*
 * tsr_irq_latch.v: sticky interrupt flags with latched signs.
 * Assumes: event pulses come from the detection core; clear is the
 * one-cycle read strobe of the status byte.
 */
`timescale 1ns/10ps
`include "tsr_consts.vh"

module tsr_irq_latch (
    clk_sys,
    reset_n,
    evt_flag,
    evt_sign,
    stat_clear,
    stat_value
);
    input        clk_sys;
    input        reset_n;
    input  [4:0] evt_flag;
    input  [2:0] evt_sign;
    input        stat_clear;
    output [7:0] stat_value;

    reg    [7:0] stat_ff;
    genvar       gi;

    // ======================================================
    // flags: bit set wins over read clear
    // ======================================================
    generate
        for (gi = 0; gi < `TSR_N_FLAGS; gi = gi + 1) begin : g_flag
            always @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    stat_ff[gi] <= 1'b0;
                end else if (evt_flag[gi]) begin
                    stat_ff[gi] <= 1'b1;
                end else if (stat_clear) begin
                    stat_ff[gi] <= 1'b0;
                end
            end
        end
        // signs of presence, motion, ambient jump (flags 3..1)
        for (gi = 0; gi < `TSR_N_SIGNS; gi = gi + 1) begin : g_sign
            always @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    stat_ff[`TSR_F_SIGN_LSB + gi] <= 1'b0;
                end else if (evt_flag[gi + 1]) begin
                    stat_ff[`TSR_F_SIGN_LSB + gi] <= evt_sign[gi];
                end else if (stat_clear) begin
                    stat_ff[`TSR_F_SIGN_LSB + gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign stat_value = stat_ff;
endmodule

// >>> tsr_master.sv
/* bus master model issuing byte strobes; assumes they are taken on rising clk_sys. */
`timescale 1ns/10ps
module tsr_master (
    input  wire       clk_sys,
    input  wire [7:0] rd_data,
    output reg        ptr_load,
    output reg  [7:0] ptr_load_addr,
    output reg        wr_stb,
    output reg  [7:0] wr_data,
    output reg        rd_stb
);
    reg [7:0] got;
    // one strobe cycle; released data lines carry the inverse
    task go(input [2:0] s, input [7:0] x);
        begin
            {ptr_load, wr_stb, rd_stb} = s;
            ptr_load_addr = s[2] ? x : ~x;
            wr_data = s[1] ? x : ~x;
            @(posedge clk_sys);
            #1 got = rd_data;
        end
    endtask
    // clear every writable control byte after power-up
    task init;
        integer k;
        begin
            go(3'b100, 8'h14);
            for (k = 0; k < 12; k = k + 1)
                go(3'b010, 8'h00);
        end
    endtask
    initial go(3'b000, 8'h00);
endmodule

// >>> tsr_reg_bank.v
/*
 * tsr_reg_bank.v: byte-addressed register bank of the thermopile
 * sensing chip, top level.
 * Assumes: a serial engine in front delivers the address byte, write
 * bytes and read requests as one-cycle strobes on clk_sys; the filter
 * and detection core supplies samples and event pulses.
 */
`timescale 1ns/10ps
`include "tsr_consts.vh"

module tsr_reg_bank (
    clk_sys,
    reset_n,
    ptr_load,
    ptr_load_addr,
    wr_stb,
    wr_data,
    rd_stb,
    rd_data,
    object_raw_sample,
    ambient_raw_sample,
    object_filter_fast,
    object_filter_slow,
    ambient_filtered,
    motion_detect,
    presence_magnitude,
    motion_magnitude,
    ambient_jump_magnitude,
    live_condition_status,
    evt_flag,
    evt_sign,
    nvm_load_stb,
    nvm_load_addr,
    nvm_load_data,
    bus_device_address,
    fast_filter_constant,
    slow_filter_constant,
    ambient_filter_constant,
    presence_threshold,
    motion_threshold,
    ambient_jump_threshold,
    interrupt_enable_mask,
    motion_cycle_sel,
    presence_src_sel,
    overtemp_dir,
    periodic_timer_setting,
    overtemp_threshold,
    nvm_access_control,
    int_n
);
    input         clk_sys;
    input         reset_n;
    input         ptr_load;
    input  [7:0]  ptr_load_addr;
    input         wr_stb;
    input  [7:0]  wr_data;
    input         rd_stb;
    output [7:0]  rd_data;
    input  [16:0] object_raw_sample;
    input  [14:0] ambient_raw_sample;
    input  [19:0] object_filter_fast;
    input  [19:0] object_filter_slow;
    input  [15:0] ambient_filtered;
    input         motion_detect;
    input  [7:0]  presence_magnitude;
    input  [7:0]  motion_magnitude;
    input  [7:0]  ambient_jump_magnitude;
    input  [7:0]  live_condition_status;
    input  [4:0]  evt_flag;
    input  [2:0]  evt_sign;
    input         nvm_load_stb;
    input  [4:0]  nvm_load_addr;
    input  [7:0]  nvm_load_data;
    input  [7:0]  bus_device_address;
    output [3:0]  fast_filter_constant;
    output [3:0]  slow_filter_constant;
    output [3:0]  ambient_filter_constant;
    output [7:0]  presence_threshold;
    output [7:0]  motion_threshold;
    output [7:0]  ambient_jump_threshold;
    output [4:0]  interrupt_enable_mask;
    output [1:0]  motion_cycle_sel;
    output [1:0]  presence_src_sel;
    output        overtemp_dir;
    output [7:0]  periodic_timer_setting;
    output [15:0] overtemp_threshold;
    output [7:0]  nvm_access_control;
    output        int_n;

    // ======================================================
    // declarations
    // ======================================================
    wire   [5:0]  ptr;
    wire   [7:0]  int_stat;
    wire          ptr_advance;
    wire          stat_clear;
    wire          wr_go;
    wire          rd_go;

    reg    [31:0] img_raw_ff;       // bytes 1..4
    reg    [39:0] img_filt_ff;      // bytes 5..9
    reg    [15:0] img_amb_ff;       // bytes 10..11
    reg    [23:0] snap_ff;          // bytes 12..14
    reg    [23:0] img_snap_ff;
    reg    [7:0]  img_pres_ff;
    reg    [7:0]  img_mot_ff;
    reg    [7:0]  img_jump_ff;
    reg    [7:0]  img_live_ff;

    reg    [7:0]  filt12_ff;
    reg    [7:0]  filt3_ff;
    reg    [7:0]  pres_thr_ff;
    reg    [7:0]  mot_thr_ff;
    reg    [7:0]  jump_thr_ff;
    reg    [7:0]  int_mask_ff;
    reg    [7:0]  det_cfg_ff;
    reg    [7:0]  timer_ff;
    reg    [15:0] ot_thr_ff;
    reg    [7:0]  nvm_ctrl_ff;

    reg    [7:0]  nvm_mem [0:30];
    reg    [7:0]  rd_data_ff;
    reg    [7:0]  nxt_rd_data;
    reg    [5:0]  nvm_idx;
    reg           int_n_ff;

    // ======================================================
    // strobe qualification
    // ======================================================
    // a write takes the cycle when both strobes arrive together
    assign wr_go       = wr_stb;
    assign rd_go       = rd_stb & ~wr_stb;
    assign ptr_advance = wr_go | rd_go;
    assign stat_clear  = rd_go & (ptr == `TSR_A_INT_STAT);

    // ======================================================
    // address pointer
    // ======================================================
    tsr_addr_ptr u_ptr (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .ptr_load      (ptr_load),
        .ptr_load_addr (ptr_load_addr),
        .ptr_advance   (ptr_advance),
        .ptr_value     (ptr)
    );

    // ======================================================
    // interrupt status latch
    // ======================================================
    tsr_irq_latch u_irq (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .evt_flag   (evt_flag),
        .evt_sign   (evt_sign),
        .stat_clear (stat_clear),
        .stat_value (int_stat)
    );

    // ======================================================
    // motion snapshot of the slow object filter
    // ======================================================
    // slow filter carries scale 8; shifting by 4 gives scale 128
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            snap_ff <= 24'h000000;
        end else if (motion_detect) begin
            snap_ff <= {object_filter_slow, 4'h0};
        end
    end

    // ======================================================
    // read image of live values
    // ======================================================
    // frozen when the address byte arrives so that a burst
    // over a multi-byte field never mixes two samples
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            img_raw_ff  <= 32'h00000000;
            img_filt_ff <= 40'h0000000000;
            img_amb_ff  <= `TSR_RST_WORD;
            img_snap_ff <= 24'h000000;
            img_pres_ff <= `TSR_RST_BYTE;
            img_mot_ff  <= `TSR_RST_BYTE;
            img_jump_ff <= `TSR_RST_BYTE;
            img_live_ff <= `TSR_RST_BYTE;
        end else if (ptr_load) begin
            // object msb in byte 1, ambient lsb in byte 4
            img_raw_ff  <= {object_raw_sample,
                            ambient_raw_sample};
            img_filt_ff <= {object_filter_fast,
                            object_filter_slow};
            img_amb_ff  <= ambient_filtered;
            img_snap_ff <= snap_ff;
            img_pres_ff <= presence_magnitude;
            img_mot_ff  <= motion_magnitude;
            img_jump_ff <= ambient_jump_magnitude;
            img_live_ff <= live_condition_status;
        end
    end

    // ======================================================
    // writable control registers
    // ======================================================
    // undefined to the master until it writes them; zero here
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            filt12_ff   <= `TSR_RST_BYTE;
            filt3_ff    <= `TSR_RST_BYTE;
            pres_thr_ff <= `TSR_RST_BYTE;
            mot_thr_ff  <= `TSR_RST_BYTE;
            jump_thr_ff <= `TSR_RST_BYTE;
            int_mask_ff <= `TSR_RST_BYTE;
            det_cfg_ff  <= `TSR_RST_BYTE;
            timer_ff    <= `TSR_RST_BYTE;
            ot_thr_ff   <= `TSR_RST_WORD;
            nvm_ctrl_ff <= `TSR_RST_BYTE;
        end else if (wr_go) begin
            // other addresses fall through unchanged
            case (ptr)
                `TSR_A_FILT12: begin
                    filt12_ff <= wr_data;
                end
                `TSR_A_FILT3: begin
                    filt3_ff <= wr_data & `TSR_M_FILT3;
                end
                `TSR_A_PRES_THR: begin
                    pres_thr_ff <= wr_data;
                end
                `TSR_A_MOT_THR: begin
                    mot_thr_ff <= wr_data;
                end
                `TSR_A_JUMP_THR: begin
                    jump_thr_ff <= wr_data;
                end
                `TSR_A_INT_MASK: begin
                    int_mask_ff <= wr_data & `TSR_M_INT_MASK;
                end
                `TSR_A_DET_CFG: begin
                    det_cfg_ff <= wr_data & `TSR_M_DET_CFG;
                end
                `TSR_A_TIMER: begin
                    timer_ff <= wr_data;
                end
                `TSR_A_OT_THR: begin
                    ot_thr_ff[15:8] <= wr_data;
                end
                `TSR_A_OT_THR + 6'h01: begin
                    ot_thr_ff[7:0] <= wr_data;
                end
                `TSR_A_NVM_CTRL: begin
                    nvm_ctrl_ff <= wr_data;
                end
                default: begin
                    nvm_ctrl_ff <= nvm_ctrl_ff;
                end
            endcase
        end
    end

    // ======================================================
    // non-volatile contents window
    // ======================================================
    // filled by the nvm sequencer; the bus cannot write it
    always @(posedge clk_sys) begin
        if (nvm_load_stb && (nvm_load_addr != 5'h1f)) begin
            nvm_mem[nvm_load_addr] <= nvm_load_data;
        end
    end

    // index into the window for the current pointer
    always @* begin
        nvm_idx = ptr - `TSR_A_NVM_FIRST;
    end

    // ======================================================
    // read multiplexer
    // ======================================================
    always @* begin
        nxt_rd_data = `TSR_RST_BYTE;
        case (ptr)
            `TSR_A_OBJ_RAW: begin
                nxt_rd_data = img_raw_ff[31:24];
            end
            `TSR_A_OBJ_RAW + 6'h01: begin
                nxt_rd_data = img_raw_ff[23:16];
            end
            `TSR_A_AMB_RAW: begin
                nxt_rd_data = img_raw_ff[15:8];
            end
            `TSR_A_AMB_RAW + 6'h01: begin
                nxt_rd_data = img_raw_ff[7:0];
            end
            `TSR_A_OBJ_FAST: begin
                nxt_rd_data = img_filt_ff[39:32];
            end
            `TSR_A_OBJ_FAST + 6'h01: begin
                nxt_rd_data = img_filt_ff[31:24];
            end
            `TSR_A_OBJ_SLOW: begin
                nxt_rd_data = img_filt_ff[23:16];
            end
            `TSR_A_OBJ_SLOW + 6'h01: begin
                nxt_rd_data = img_filt_ff[15:8];
            end
            `TSR_A_OBJ_SLOW + 6'h02: begin
                nxt_rd_data = img_filt_ff[7:0];
            end
            `TSR_A_AMB_FILT: begin
                nxt_rd_data = img_amb_ff[15:8];
            end
            `TSR_A_AMB_FILT + 6'h01: begin
                nxt_rd_data = img_amb_ff[7:0];
            end
            `TSR_A_SNAP: begin
                nxt_rd_data = img_snap_ff[23:16];
            end
            `TSR_A_SNAP + 6'h01: begin
                nxt_rd_data = img_snap_ff[15:8];
            end
            `TSR_A_SNAP + 6'h02: begin
                nxt_rd_data = img_snap_ff[7:0];
            end
            `TSR_A_PRES_MAG: begin
                nxt_rd_data = img_pres_ff;
            end
            `TSR_A_MOT_MAG: begin
                nxt_rd_data = img_mot_ff;
            end
            `TSR_A_JUMP_MAG: begin
                nxt_rd_data = img_jump_ff;
            end
            `TSR_A_INT_STAT: begin
                nxt_rd_data = int_stat;
            end
            `TSR_A_LIVE_STAT: begin
                nxt_rd_data = img_live_ff;
            end
            `TSR_A_FILT12: begin
                nxt_rd_data = filt12_ff;
            end
            `TSR_A_FILT3: begin
                nxt_rd_data = filt3_ff;
            end
            `TSR_A_PRES_THR: begin
                nxt_rd_data = pres_thr_ff;
            end
            `TSR_A_MOT_THR: begin
                nxt_rd_data = mot_thr_ff;
            end
            `TSR_A_JUMP_THR: begin
                nxt_rd_data = jump_thr_ff;
            end
            `TSR_A_INT_MASK: begin
                nxt_rd_data = int_mask_ff;
            end
            `TSR_A_DET_CFG: begin
                nxt_rd_data = det_cfg_ff;
            end
            `TSR_A_TIMER: begin
                nxt_rd_data = timer_ff;
            end
            `TSR_A_OT_THR: begin
                nxt_rd_data = ot_thr_ff[15:8];
            end
            `TSR_A_OT_THR + 6'h01: begin
                nxt_rd_data = ot_thr_ff[7:0];
            end
            `TSR_A_NVM_CTRL: begin
                nxt_rd_data = nvm_ctrl_ff;
            end
            `TSR_A_BUS_ADDR: begin
                nxt_rd_data = bus_device_address;
            end
            default: begin
                // window 0x20..0x3e, reserved bytes read zero
                if (ptr >= `TSR_A_NVM_FIRST) begin
                    nxt_rd_data = nvm_mem[nvm_idx[4:0]];
                end
            end
        endcase
    end

    // ======================================================
    // read data register
    // ======================================================
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_ff <= `TSR_RST_BYTE;
        end else if (rd_go) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // ======================================================
    // interrupt pin
    // ======================================================
    // low while any enabled latched flag stands
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            int_n_ff <= 1'b1;
        end else begin
            int_n_ff <= ~|(int_stat[4:0] & int_mask_ff[4:0]);
        end
    end

    // ======================================================
    // outputs
    // ======================================================
    assign rd_data                 = rd_data_ff;
    assign int_n                   = int_n_ff;
    assign fast_filter_constant    = filt12_ff[3:0];
    assign slow_filter_constant    = filt12_ff[7:4];
    assign ambient_filter_constant = filt3_ff[3:0];
    assign presence_threshold      = pres_thr_ff;
    assign motion_threshold        = mot_thr_ff;
    assign ambient_jump_threshold  = jump_thr_ff;
    assign interrupt_enable_mask   = int_mask_ff[4:0];
    assign motion_cycle_sel        = det_cfg_ff[`TSR_F_CYCLE_LSB +: 2];
    assign presence_src_sel        = det_cfg_ff[`TSR_F_SRC_LSB +: 2];
    assign overtemp_dir            = det_cfg_ff[`TSR_F_OT_DIR];
    assign periodic_timer_setting  = timer_ff;
    assign overtemp_threshold      = ot_thr_ff;
    assign nvm_access_control      = nvm_ctrl_ff;
endmodule

// >>> tsr_reg_bank_assertions.sv
/* port checker for tsr_reg_bank; assumes the bind below. */
`timescale 1ns/10ps
module tsr_chk (
    input wire       clk_sys,
    input wire       reset_n,
    input wire       ptr_load,
    input wire [7:0] ptr_load_addr,
    input wire       wr_stb,
    input wire [7:0] wr_data,
    input wire       rd_stb,
    input wire [7:0] rd_data,
    input wire [4:0] evt_flag,
    input wire [7:0] presence_threshold,
    input wire [3:0] fast_filter_constant,
    input wire [4:0] interrupt_enable_mask,
    input wire       int_n
);
    reg [5:0] pt_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ====
    // pointer followed from the strobes
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            pt_ff <= 6'h00;
        else if (ptr_load)
            pt_ff <= ptr_load_addr[5:0];
        else if (wr_stb || rd_stb)
            pt_ff <= pt_ff + 6'h01;
    end
    property p_wr; wr_stb && pt_ff == 6'h16 |=> presence_threshold == $past(wr_data); endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_wr2; wr_stb && pt_ff == 6'h14 |=> fast_filter_constant == $past(wr_data[3:0]); endproperty
    a_wr2: assert property (p_wr2) else $error("write lost");
    property p_ro; wr_stb && pt_ff < 6'h14 |=> $stable(presence_threshold); endproperty
    a_ro: assert property (p_ro) else $error("read-only write took");
    property p_zero; rd_stb && pt_ff == 6'h00 |=> rd_data == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("byte 0 not zero");
    property p_rsv; rd_stb && pt_ff == 6'h1e |=> rd_data == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved not zero");
    property p_msk; rd_stb && pt_ff == 6'h15 |=> rd_data[7:4] == 4'h0; endproperty
    a_msk: assert property (p_msk) else $error("reserved bits set");
    property p_rel; rd_stb && !wr_stb && pt_ff == 6'h12 && evt_flag == 5'h00 |-> ##2 int_n; endproperty
    a_rel: assert property (p_rel) else $error("pin not released");
    property p_irq; evt_flag[2] && interrupt_enable_mask[2] |-> ##2 !int_n; endproperty
    a_irq: assert property (p_irq) else $error("pin not raised");
endmodule
bind tsr_reg_bank tsr_chk chk (.clk_sys, .reset_n, .ptr_load, .ptr_load_addr, .wr_stb,
    .wr_data, .rd_stb, .rd_data, .evt_flag, .presence_threshold, .fast_filter_constant,
    .interrupt_enable_mask, .int_n);
